// File: logic/hpsm_pkg.sv
// shared types and constants for the host port mode strap mux
package hpsm_pkg;

  // ==========================================================
  // strap decoding
  localparam int          STRAP_W      = 3;
  localparam int          STRAP_SEL_LO = 0;
  localparam int          STRAP_SEL_HI = 1;
  localparam int          STRAP_STYLE  = 2;
  localparam logic [1:0]  SEL_PARALLEL = 2'h3;
  localparam logic [1:0]  SEL_SERIAL   = 2'h1;
  localparam logic        STYLE_SEP    = 1'h0;
  localparam logic [2:0]  STRAP_RST    = 3'h0;

  // ==========================================================
  // widths and reset values
  localparam int          DATA_W       = 8;
  localparam int          ADDR_W       = 2;
  localparam int          NUM_HREGS    = 4;
  localparam logic [7:0]  DATA_RST     = 8'h00;
  localparam logic [1:0]  ADDR_RST     = 2'h0;

  typedef enum logic [1:0] {
    HPSM_MODE_OFF,
    HPSM_MODE_PAR_SEP,
    HPSM_MODE_PAR_DIR,
    HPSM_MODE_SPI
  } hpsm_mode_t;

  typedef enum logic [1:0] {
    HPSM_BUS_IDLE,
    HPSM_BUS_READ,
    HPSM_BUS_WRITE
  } hpsm_bus_t;

  // pin levels seen from the board, sampled on clock
  typedef struct packed {
    logic [7:0] data;
    logic       addr_lo;
    logic       addr_hi;
    logic       chip_select_n;
    logic [2:0] strap;
  } hpsm_pin_in_t;

  // pin drive; an enable low means the pin is driven
  typedef struct packed {
    logic [7:0] data;
    logic [7:0] data_oe_n;
    logic [2:0] strap;
    logic [2:0] strap_oe_n;
    logic       irq;
    logic       irq_oe_n;
  } hpsm_pin_out_t;

  // parallel access events towards the first core
  typedef struct packed {
    logic       wr_pulse;
    logic       rd_pulse;
    logic [1:0] addr;
    logic [7:0] wdata;
  } hpsm_par_evt_t;

  // serial port levels towards the first core
  typedef struct packed {
    logic sel;
    logic clk;
    logic din;
  } hpsm_spi_t;

endpackage

// File: logic/hpsm_top.sv
// strap capture and host port pin multiplexing for the first core
// ==========================================================
// Operation
// RULE1: latch three mode straps at reset release
// RULE2: async reset; bidirectional pins released meanwhile
// RULE3: latch second core strap set too
// RULE4: parallel data pins bidirectional, default input
// RULE5: two address pins pick one of four
// RULE6: serial mode: address pins, strap2 carry SPI
// RULE7: host drives chip select low to access
// RULE8: separate style: read enable, write strobe
// RULE9: direction style: direction plus data strobe
// RULE10: serial mode may drive memory enables
// RULE11: strap bit2 picks parallel bus style
// RULE12: irq pulled low while outgoing data waits
// RULE13: irq released once host read everything
`timescale 1ns/1ps

module hpsm_top
  import hpsm_pkg::*;
#(
  parameter int WIDTH = DATA_W
) (
  input  wire logic          clock,
  input  wire logic          resetn,
  input  wire logic          clk_en,
  input  wire hpsm_pin_in_t  pin_in,
  input  wire logic [2:0]    second_core_strap,
  input  wire logic [7:0]    core_rd_data,
  input  wire logic          core_spi_out,
  input  wire logic          core_mem_en,
  input  wire logic          core_mem_de_n,
  input  wire logic          core_mem_we_n,
  input  wire logic          core_out_pending,
  output hpsm_pin_out_t      pin_out,
  output hpsm_par_evt_t      par_evt,
  output hpsm_spi_t          spi,
  output hpsm_mode_t         mode,
  output logic [2:0]         second_core_mode,
  output logic               straps_valid
);

  // ==========================================================
  // strap capture

  logic       armed_q;
  logic       armed_d;
  logic       capture;
  hpsm_mode_t mode_q;
  hpsm_mode_t mode_d;
  logic [2:0] sc_mode_q;
  logic [2:0] sc_mode_d;
  logic       valid_q;

  function automatic hpsm_mode_t decode_strap(input logic [2:0] s);
    hpsm_mode_t m;
    m = HPSM_MODE_OFF;
    if (s[STRAP_SEL_HI:STRAP_SEL_LO] == SEL_PARALLEL) begin
      m = (s[STRAP_STYLE] == STYLE_SEP) ? HPSM_MODE_PAR_SEP
                                        : HPSM_MODE_PAR_DIR;
    end else if (s[STRAP_SEL_HI:STRAP_SEL_LO] == SEL_SERIAL) begin
      m = HPSM_MODE_SPI;
    end
    return m;
  endfunction

  // first enabled clock after release takes the straps; an async flop may
  // only load constants, so the pins are caught synchronously here
  assign capture   = armed_q & clk_en;
  assign armed_d   = capture ? 1'b0 : armed_q;
  // see RULE1, see RULE11
  assign mode_d    = capture ? decode_strap(pin_in.strap) : mode_q;
  // see RULE3
  assign sc_mode_d = capture ? second_core_strap : sc_mode_q;

  // see RULE2
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      armed_q <= 1'b1;
    end else begin
      armed_q <= armed_d;
    end
  end

  // a flop of its own, so the valid output needs no inverter
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= ~armed_d;
    end
  end

  // the port mode stands until the next master reset
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mode_q <= HPSM_MODE_OFF;
    end else begin
      mode_q <= mode_d;
    end
  end

  // second core straps are only recorded here
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sc_mode_q <= STRAP_RST;
    end else begin
      sc_mode_q <= sc_mode_d;
    end
  end

  // ==========================================================
  // parallel host access

  wire is_sep = (mode_q == HPSM_MODE_PAR_SEP);
  wire is_dir = (mode_q == HPSM_MODE_PAR_DIR);
  wire is_spi = (mode_q == HPSM_MODE_SPI);
  wire cs_act = ~pin_in.chip_select_n;

  // a strobe counts only while the chip select is held low
  function automatic logic strobe_low(input logic cs_n, input logic level);
    return ~cs_n & ~level;
  endfunction

  // see RULE8
  wire sep_rd = is_sep & strobe_low(pin_in.chip_select_n, pin_in.strap[STRAP_SEL_HI]);
  wire sep_wr = is_sep & strobe_low(pin_in.chip_select_n, pin_in.strap[STRAP_SEL_LO]);
  // see RULE9
  wire dir_ds = is_dir & strobe_low(pin_in.chip_select_n, pin_in.strap[STRAP_SEL_LO]);
  wire dir_rd = dir_ds & pin_in.strap[STRAP_SEL_HI];
  wire dir_wr = dir_ds & ~pin_in.strap[STRAP_SEL_HI];

  // see RULE7
  wire want_rd = sep_rd | dir_rd;
  wire want_wr = (sep_wr | dir_wr) & ~want_rd;

  hpsm_bus_t        bus_q;
  hpsm_bus_t        bus_d;
  logic [1:0]       addr_q;
  logic [1:0]       addr_d;
  logic [WIDTH-1:0] wdata_q;
  logic [WIDTH-1:0] wdata_d;
  logic             wr_pulse_d;
  logic             rd_pulse_d;

  // see RULE5
  wire [1:0] pin_addr = {pin_in.addr_hi, pin_in.addr_lo};

  // writes commit at strobe release so the host data has settled;
  // reads report at their end so the core pops only once
  always_comb begin
    bus_d      = bus_q;
    addr_d     = addr_q;
    wdata_d    = wdata_q;
    wr_pulse_d = 1'b0;
    rd_pulse_d = 1'b0;
    unique case (bus_q)
      HPSM_BUS_IDLE: begin
        if (want_rd) begin
          bus_d  = HPSM_BUS_READ;
          addr_d = pin_addr;
        end else if (want_wr) begin
          bus_d   = HPSM_BUS_WRITE;
          addr_d  = pin_addr;
          wdata_d = pin_in.data[WIDTH-1:0];
        end
      end
      HPSM_BUS_READ: begin
        if (!want_rd) begin
          bus_d      = HPSM_BUS_IDLE;
          rd_pulse_d = 1'b1;
        end
      end
      HPSM_BUS_WRITE: begin
        if (want_wr) begin
          wdata_d = pin_in.data[WIDTH-1:0];
          addr_d  = pin_addr;
        end else begin
          bus_d      = HPSM_BUS_IDLE;
          wr_pulse_d = 1'b1;
        end
      end
      // the unused code falls back to idle
      default: begin
        bus_d = HPSM_BUS_IDLE;
      end
    endcase
  end

  // a low clock enable freezes the access where it stands
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bus_q <= HPSM_BUS_IDLE;
    end else if (clk_en) begin
      bus_q <= bus_d;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      addr_q <= ADDR_RST;
    end else if (clk_en) begin
      addr_q <= addr_d;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wdata_q <= DATA_RST;
    end else if (clk_en) begin
      wdata_q <= wdata_d;
    end
  end

  // ==========================================================
  // pin drive

  hpsm_pin_out_t pin_d;
  hpsm_pin_out_t pin_q;
  logic [2:0]    strap_val;
  logic [2:0]    strap_en;

  wire drive_rd  = want_rd;
  wire spi_drive = is_spi & cs_act;
  // see RULE10
  wire mem_drive = is_spi & core_mem_en;

  // bytes leave only while a read strobe is seen; the pull-ups hold the bus
  // see RULE4
  for (genvar i = 0; i < DATA_W; i++) begin : g_data_pin
    assign pin_d.data[i]      = core_rd_data[i];
    assign pin_d.data_oe_n[i] = ~drive_rd;
  end

  // see RULE6, see RULE10
  assign strap_val = {core_spi_out, core_mem_de_n, core_mem_we_n};
  assign strap_en  = {spi_drive, mem_drive, mem_drive};
  for (genvar k = 0; k < STRAP_W; k++) begin : g_strap_pin
    assign pin_d.strap[k]      = strap_val[k];
    assign pin_d.strap_oe_n[k] = ~strap_en[k];
  end
  // open drain: the data level is always low, only the enable moves
  // see RULE12, see RULE13
  assign pin_d.irq        = 1'b0;
  assign pin_d.irq_oe_n   = ~(core_out_pending & ~armed_q);

  // see RULE2
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pin_q.data       <= DATA_RST;
      pin_q.data_oe_n  <= 8'hff;
      pin_q.strap      <= STRAP_RST;
      pin_q.strap_oe_n <= 3'h7;
      pin_q.irq        <= 1'b0;
      pin_q.irq_oe_n   <= 1'b1;
    end else if (clk_en) begin
      pin_q <= pin_d;
    end
  end

  // ==========================================================
  // core side

  hpsm_par_evt_t evt_q;
  hpsm_spi_t     spi_q;

  // pulses last one enabled cycle; addr and wdata stand until the next access
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      evt_q.wr_pulse <= 1'b0;
      evt_q.rd_pulse <= 1'b0;
      evt_q.addr     <= ADDR_RST;
      evt_q.wdata    <= DATA_RST;
    end else if (clk_en) begin
      evt_q.wr_pulse <= wr_pulse_d;
      evt_q.rd_pulse <= rd_pulse_d;
      evt_q.addr     <= addr_d;
      evt_q.wdata    <= wdata_d;
    end
  end

  // serial levels pass one flop so the core sees them settled
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      spi_q.sel <= 1'b0;
      spi_q.clk <= 1'b0;
      spi_q.din <= 1'b0;
    end else if (clk_en) begin
      // see RULE6
      spi_q.sel <= spi_drive;
      spi_q.clk <= is_spi & pin_in.addr_lo;
      spi_q.din <= is_spi & pin_in.addr_hi;
    end
  end

  assign pin_out          = pin_q;
  assign par_evt          = evt_q;
  assign spi              = spi_q;
  assign mode             = mode_q;
  assign second_core_mode = sc_mode_q;
  assign straps_valid     = valid_q;

endmodule

// File: verif/hpsm_host.sv
// host model driving the control port pins
`timescale 1ns/1ps
module hpsm_host (
  input  wire logic       clock,
  input  wire logic [7:0] bus,
  output logic            cs_n  = 1'h1,
  output logic [1:0]      addr  = 2'h0,
  output logic [2:0]      strap = 3'h7,
  output logic [7:0]      wd    = 8'h00,
  output logic            wd_en = 1'h0,
  output logic [7:0]      rdata = 8'h00
);
  // strobe held three cycles so the device samples it three times
  task automatic acc(input logic sep, input logic rd, input logic [1:0] a, input logic [7:0] d);
    @(negedge clock);
    cs_n = 1'h0;
    addr = a;
    wd = d;
    wd_en = !rd;
    strap[1:0] = rd ? (sep ? 2'h1 : 2'h2) : {sep, 1'h0};
    repeat (3) @(negedge clock);
    rdata = bus;
    strap[1:0] = 2'h3;
    cs_n = 1'h1;
    wd_en = 1'h0;
  endtask
endmodule

// File: verif/hpsm_top_sva.sv
// assertions on the strap mux ports
`timescale 1ns/1ps
module hpsm_sva
  import hpsm_pkg::*;
(
  input wire logic          clock,
  input wire logic          resetn,
  input wire logic          clk_en,
  input wire hpsm_pin_in_t  pin_in,
  input wire logic          core_spi_out,
  input wire logic          core_out_pending,
  input wire hpsm_pin_out_t pin_out,
  input wire hpsm_par_evt_t par_evt,
  input wire hpsm_spi_t     spi,
  input wire logic [1:0]    mode,
  input wire logic          straps_valid
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn || !clk_en);
  wire logic       cs = !pin_in.chip_select_n;
  wire logic [1:0] st = pin_in.strap[1:0];
  wire logic [1:0] em = st != SEL_PARALLEL ? (st == SEL_SERIAL ? HPSM_MODE_SPI : HPSM_MODE_OFF)
    : pin_in.strap[STRAP_STYLE] ? HPSM_MODE_PAR_DIR : HPSM_MODE_PAR_SEP;
  reset_float_a: assert property (disable iff (1'h0) !resetn |->
    &{pin_out.data_oe_n, pin_out.strap_oe_n, pin_out.irq_oe_n}) else $error("driven in reset");
  strap_cap_a: assert property ($rose(straps_valid) |-> mode == $past(em))
    else $error("bad strap capture");
  mode_hold_a: assert property (straps_valid |=> straps_valid && $stable(mode))
    else $error("mode moved");
  sep_read_a: assert property (mode == HPSM_MODE_PAR_SEP && cs && !st[1]
    |=> !pin_out.data_oe_n && par_evt.addr == $past({pin_in.addr_hi, pin_in.addr_lo}))
    else $error("read lost");
  dir_read_a: assert property (mode == HPSM_MODE_PAR_DIR && cs && st == 2'h2
    |=> !pin_out.data_oe_n) else $error("dir read lost");
  write_end_a: assert property (mode == HPSM_MODE_PAR_SEP && cs && st == 2'h2
    ##1 st[0] |=> par_evt.wr_pulse && par_evt.wdata == $past(pin_in.data, 2))
    else $error("write lost");
  spi_pass_a: assert property (mode == HPSM_MODE_SPI && cs |=>
    spi == {1'h1, $past(pin_in.addr_lo), $past(pin_in.addr_hi)} && !pin_out.strap_oe_n[2]
    && pin_out.strap[2] == $past(core_spi_out)) else $error("serial pins wrong");
  irq_follow_a: assert property (straps_valid |=> !pin_out.irq
    && pin_out.irq_oe_n == !$past(core_out_pending)) else $error("irq wrong");
endmodule

bind hpsm_top hpsm_sva u_sva (.clock, .resetn, .clk_en, .pin_in, .core_spi_out,
  .core_out_pending, .pin_out, .par_evt, .spi, .mode, .straps_valid);

// File: verif/hpsm_top_test.sv
// self-checking bench for the strap mux
`timescale 1ns/1ps
module hpsm_top_test;
  import hpsm_pkg::*;
  logic            clock = 1'h0, resetn = 1'h1, core_spi_out = 1'h0, core_mem_en = 1'h0, rd;
  logic            core_mem_de_n = 1'h1, core_mem_we_n = 1'h1, core_out_pending = 1'h0;
  logic [1:0]      ad;
  logic [2:0]      second_core_strap = 3'h0, second_core_mode;
  logic [7:0]      core_rd_data = 8'h00, d;
  logic [9:0]      wq[$];
  logic [1:0]      rq[$];
  int              error_cnt = 0, checks = 0, cyc = 0;
  wire logic       hde;
  wire logic [2:0] hs;
  wire logic [7:0] hd, rdata;
  wire hpsm_pin_in_t pin_in;
  hpsm_pin_out_t   pin_out;
  hpsm_par_evt_t   par_evt;
  hpsm_spi_t       spi;
  hpsm_mode_t      mode;
  logic            straps_valid;
  always #5 clock = ~clock;
  // released pins rest at their pull-ups
  assign pin_in.data = pin_out.data & ~pin_out.data_oe_n | (hde ? hd : 8'hff) & pin_out.data_oe_n;
  assign pin_in.strap = pin_out.strap & ~pin_out.strap_oe_n | hs & pin_out.strap_oe_n;
  hpsm_top uut (.clock, .resetn, .clk_en(1'h1), .pin_in, .second_core_strap, .core_rd_data,
    .core_spi_out, .core_mem_en, .core_mem_de_n, .core_mem_we_n, .core_out_pending, .pin_out,
    .par_evt, .spi, .mode, .second_core_mode, .straps_valid);
  hpsm_host host (.clock, .bus(pin_in.data), .cs_n(pin_in.chip_select_n), .strap(hs), .wd(hd),
    .addr({pin_in.addr_hi, pin_in.addr_lo}), .wd_en(hde), .rdata);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc > 5000) begin
      error_cnt++;
      stop_test();
    end
  end
  // writes are scored in issue order
  always @(negedge clock) if (par_evt.wr_pulse === 1'h1) begin
    chk(par_evt.wdata, wq[0][7:0]);
    chk(par_evt.addr, wq[0][9:8]);
    void'(wq.pop_front());
  end
  // reads end with a pulse that names the register read
  always @(negedge clock) if (par_evt.rd_pulse === 1'h1) begin
    chk(par_evt.addr, rq[0]);
    void'(rq.pop_front());
  end
  initial begin
    void'($urandom(85));
    #1 resetn = 1'h0;
    for (int s = 0; s < 8; s++) begin
      @(negedge clock);
      resetn = 1'h0;
      host.strap = s[2:0];
      second_core_strap = $urandom;
      repeat (2) @(negedge clock);
      chk(pin_out.data_oe_n, 8'hff);
      chk(straps_valid, 1'h0);
      resetn = 1'h1;
      repeat (2) @(negedge clock);
      host.strap = 3'h7;
      chk(second_core_mode, second_core_strap);
      chk(straps_valid, 1'h1);
      if (s % 4 == 3) repeat (6) begin
        {d, ad, rd} = $urandom;
        core_rd_data = $urandom;
        if (!rd) wq.push_back({ad, d});
        else rq.push_back(ad);
        host.acc(s < 4, rd, ad, d);
        if (rd) chk(host.rdata, core_rd_data);
      end
      if (s % 4 == 1) repeat (6) begin
        {core_spi_out, core_mem_en, core_mem_de_n, core_mem_we_n, host.addr} = $urandom;
        host.cs_n = 1'h0;
        repeat (2) @(negedge clock);
        chk(spi, {1'h1, host.addr[0], host.addr[1]});
        d = {core_spi_out, core_mem_en ? {core_mem_de_n, core_mem_we_n} : 2'h3};
        chk(pin_in.strap, d);
      end
      host.cs_n = 1'h1;
      core_out_pending = 1'h1;
      repeat (2) @(negedge clock);
      chk(pin_out.irq_oe_n, 1'h0);
      core_out_pending = 1'h0;
      repeat (2) @(negedge clock);
      chk(pin_out.irq_oe_n, 1'h1);
      d = s % 4 == 1 ? HPSM_MODE_SPI : s == 3 ? HPSM_MODE_PAR_SEP
        : s == 7 ? HPSM_MODE_PAR_DIR : HPSM_MODE_OFF;
      chk(mode, d);
    end
    chk(8'(wq.size() + rq.size()), 8'h00);
    stop_test();
  end
endmodule
